// *** include/irq_accept_pkg.sv ***
// Constants, field positions and carrier types of the interrupt accept sequencer.
package irq_accept_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_SRC = 20;
  localparam int NUM_PRIO = 5;
  localparam int LVL_W = 4;
  localparam int IDX_W = 5;
  localparam int CODE_W = 12;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_VBASE = 12'h004;
  localparam logic [11:0] OFS_CODE = 12'h008;
  localparam logic [11:0] OFS_CODE_B = 12'h00c;
  localparam logic [11:0] OFS_SAVED_ST = 12'h010;
  localparam logic [11:0] OFS_SAVED_PC = 12'h014;
  localparam logic [11:0] OFS_FLAGS2 = 12'h018;
  localparam logic [11:0] OFS_PRIO0 = 12'h020;
  localparam logic [11:0] OFS_PRIO4 = 12'h030;

  // ==========================================================================
  // Status word field positions
  localparam int ST_MD_BIT = 30;
  localparam int ST_RB_BIT = 29;
  localparam int ST_BL_BIT = 28;
  localparam int ST_MASK_LSB = 4;

  // ==========================================================================
  // Request flag register: bit positions and the source index feeding each
  localparam int FLAG_ADC_BIT = 4;
  localparam int FLAG_TX_BIT = 3;
  localparam int FLAG_BRK_BIT = 2;
  localparam int FLAG_RX_BIT = 1;
  localparam int FLAG_ERR_BIT = 0;
  localparam int SRC_ADC = 15;
  localparam int SRC_ERR = 16;
  localparam int SRC_RX = 17;
  localparam int SRC_BRK = 18;
  localparam int SRC_TX = 19;

  // ==========================================================================
  // Reset values and fixed numbers
  localparam logic [7:0] FLAGS2_RST = 8'h00;
  localparam logic [31:0] VECTOR_OFFSET = 32'h0000_0600;
  localparam logic [CODE_W-1:0] CODE_BASE = 12'h400;
  localparam logic [CODE_W-1:0] CODE_STRIDE = 12'h020;

  // CPU status bits that the sequencer owns.
  typedef struct packed {
    logic hold;
    logic md;
    logic rb;
    logic [LVL_W-1:0] mask;
  } status_t;

  // Status after reset: held, privileged, bank zero, every level masked.
  localparam status_t STATUS_RST = '{hold: 1'b1, md: 1'b1, rb: 1'b0, mask: 4'hf};

  // Winner of the priority decision.
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [LVL_W-1:0] level;
  } pick_t;

endpackage

// *** rtl/interrupt_accept_sequencer.sv ***
// Interrupt accept sequencer: arbitration, mask compare, exception entry, AHB-Lite registers.
// Summary of operation
// RL1: Request flag register two is 8-bit read-only, reset to zero, kept in standby.
// RL2: Upper three flag bits always read zero; software writes zero there.
// RL3: Flag bit four shows the converter completion request.
// RL4: Flag bit three shows the serial port transmit request.
// RL5: Flag bit two shows the serial port break request.
// RL6: Flag bit one shows the serial port receive request.
// RL7: Flag bit zero shows the serial port receive error request.
// RL8: Highest programmed level among active requests wins; others stay pending.
// RL9: Equal levels are resolved by fixed source order.
// RL10: Accept only when the winning level is strictly above the status mask.
// RL11: Acceptance drives the pending output low.
// RL12: Pending output stays low until source clears; hold bit ignored.
// RL13: Pending output returns high once the mask covers the source.
// RL14: Everything runs on the peripheral clock; entry only at instruction boundaries.
// RL15: Acceptance writes the source code into both event registers.
// RL16: Acceptance copies status to saved status and PC to saved PC.
// RL17: Acceptance sets hold, privilege and bank bits in status.
// RL18: CPU branches to vector base plus fixed offset, no delay slot.
// RL19: Acceptance leaves the status level mask unchanged.
// RL20: Handler clears source, reads back, waits decision time before unholding.
// RL21: Nesting handler dispatches, clears cause, saves copies, unholds, raises mask.
// RL22: After unhold and mask raise, a strictly higher request is accepted.
// RL23: While hold is one, exception entry is deferred.
// RL24: Each flag bit follows its live source line and drops when withdrawn.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
module interrupt_accept_sequencer
  import irq_accept_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [NUM_SRC-1:0] reqIn,
  input wire logic instrBoundary,
  input wire logic [31:0] cpuPc,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pendingRequestOutN,
  output logic exceptionTake,
  output logic [31:0] branchTarget
);

  // ==========================================================================
  // State
  status_t status_q;
  pick_t pick_q;
  pick_t pick_d;
  logic [31:0] vectorBase_q;
  logic [15:0] prio_q [NUM_PRIO];
  logic [CODE_W-1:0] sourceCodeReg_q;
  logic [CODE_W-1:0] sourceCodeRegB_q;
  logic [31:0] savedStatusCopy_q;
  logic [31:0] savedCounterCopy_q;
  logic [7:0] requestFlagsTwo_q;
  logic pendN_q;
  logic take_q;
  logic [31:0] target_q;
  logic [31:0] rdata_q;
  logic readyOut_q;
  logic respOut_q;
  logic wrPend_q;
  logic [11:0] wrAddr_q;
  logic accept;
  logic take;
  logic addrPhase;

  // Packs the owned status bits into their word layout for reads and saving.
  // Bits that the sequencer does not own read as zero.
  function automatic logic [31:0] packStatus(input status_t s);
    logic [31:0] w;
    w = '0;
    w[ST_BL_BIT] = s.hold;
    w[ST_MD_BIT] = s.md;
    w[ST_RB_BIT] = s.rb;
    w[ST_MASK_LSB +: LVL_W] = s.mask;
    return w;
  endfunction

  // Source code written to the event registers for a given source index.
  function automatic logic [CODE_W-1:0] codeOf(input logic [IDX_W-1:0] idx);
    return CODE_BASE + CODE_STRIDE * CODE_W'(idx);
  endfunction

  // True at the word address of any of the five priority registers.
  function automatic logic isPrioAddr(input logic [11:0] a);
    return (a >= OFS_PRIO0) && (a <= OFS_PRIO4) && (a[1:0] == 2'h0);
  endfunction

  // ==========================================================================
  // Request flag register two
  // Sources live on this clock, so no synchroniser; the flags mirror live lines.
  // Standby has no reset of its own here, so the flags simply keep following.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      requestFlagsTwo_q <= FLAGS2_RST; // RL1
    end else begin
      requestFlagsTwo_q[7:5] <= 3'h0; // RL2
      requestFlagsTwo_q[FLAG_ADC_BIT] <= reqIn[SRC_ADC]; // RL3
      requestFlagsTwo_q[FLAG_TX_BIT] <= reqIn[SRC_TX]; // RL4
      requestFlagsTwo_q[FLAG_BRK_BIT] <= reqIn[SRC_BRK]; // RL5
      requestFlagsTwo_q[FLAG_RX_BIT] <= reqIn[SRC_RX]; // RL6
      requestFlagsTwo_q[FLAG_ERR_BIT] <= reqIn[SRC_ERR]; // RL7 RL24
    end
  end

  // ==========================================================================
  // Priority decision
  // Strict compare keeps the lowest index on a tie; level zero never wins.
  // A plain compare chain is cheap at twenty sources and keeps the tie rule obvious.
  always_comb begin
    logic [LVL_W-1:0] lvl;
    lvl = '0;
    pick_d = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = prio_q[i / 4][(i % 4) * LVL_W +: LVL_W];
      if (reqIn[i] && (lvl > pick_d.level)) begin // RL8
        pick_d.valid = 1'b1;
        pick_d.idx = IDX_W'(i); // RL9
        pick_d.level = lvl;
      end
    end
  end

  // One cycle of decision time; this is the interval the handler must respect.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pick_q <= '0;
    end else begin
      pick_q <= pick_d; // RL14
    end
  end

  // Mask compare; the hold bit does not take part here.
  assign accept = pick_q.valid && (pick_q.level > status_q.mask); // RL10
  // Entry happens only at a boundary and never while hold is set.
  assign take = accept && !status_q.hold && instrBoundary; // RL23

  // ==========================================================================
  // Pending output
  // The pin follows the accept condition, not the entry, so it stays low while
  // the core holds off and rises one cycle after the mask is raised to cover it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pendN_q <= 1'b1;
    end else begin
      pendN_q <= !accept; // RL11 RL12 RL13
    end
  end

  // ==========================================================================
  // Exception entry
  // Both event registers get the same code, so a handler may read either one.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sourceCodeReg_q <= '0;
      sourceCodeRegB_q <= '0;
      savedStatusCopy_q <= '0;
      savedCounterCopy_q <= '0;
      target_q <= '0;
    end else if (take) begin
      sourceCodeReg_q <= codeOf(pick_q.idx); // RL15
      sourceCodeRegB_q <= codeOf(pick_q.idx); // RL15
      savedStatusCopy_q <= packStatus(status_q); // RL16
      savedCounterCopy_q <= cpuPc; // RL16
      target_q <= vectorBase_q + VECTOR_OFFSET; // RL18
    end
  end

  // The entry pulse lasts one cycle because entry sets the hold bit at once.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      take_q <= 1'b0;
    end else begin
      take_q <= take; // RL14
    end
  end

  // ==========================================================================
  // Status bits
  // Hardware entry wins over a software write in the same cycle, so the hold
  // bit can never be lost to a racing unhold.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= STATUS_RST;
    end else if (take) begin
      status_q.hold <= 1'b1; // RL17
      status_q.md <= 1'b1; // RL17
      status_q.rb <= 1'b1; // RL17
      status_q.mask <= status_q.mask; // RL19
    end else if (wrPend_q && wrAddr_q == OFS_STATUS) begin
      status_q.hold <= hwdata[ST_BL_BIT]; // RL22
      status_q.md <= hwdata[ST_MD_BIT];
      status_q.rb <= hwdata[ST_RB_BIT];
      status_q.mask <= hwdata[ST_MASK_LSB +: LVL_W];
    end
  end

  // ==========================================================================
  // AHB-Lite slave: zero wait states, OKAY always, read data set up in the
  // address phase so that it stands from a flop in the data phase.
  assign addrPhase = hsel && htrans[1] && hready;

  // Write data arrives one cycle after the address, so the intent waits in flops.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[11:0];
    end
  end

  // Writable configuration; unmapped or read-only targets ignore writes.
  // The same priority decode serves reads, so both paths agree on the map.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      vectorBase_q <= '0;
      for (int r = 0; r < NUM_PRIO; r++) begin
        prio_q[r] <= '0;
      end
    end else if (wrPend_q) begin
      if (wrAddr_q == OFS_VBASE) begin
        vectorBase_q <= hwdata;
      end else if (isPrioAddr(wrAddr_q)) begin
        prio_q[3'(wrAddr_q[4:2])] <= hwdata[15:0];
      end
    end
  end

  // Read mux; the flag register reads through with upper bits already zero.
  // Read data returns to zero outside a data phase, so nothing stale lingers.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (addrPhase && !hwrite) begin
      if (haddr[11:0] == OFS_STATUS) begin
        rdata_q <= packStatus(status_q);
      end else if (haddr[11:0] == OFS_VBASE) begin
        rdata_q <= vectorBase_q;
      end else if (haddr[11:0] == OFS_CODE) begin
        rdata_q <= {20'h0, sourceCodeReg_q};
      end else if (haddr[11:0] == OFS_CODE_B) begin
        rdata_q <= {20'h0, sourceCodeRegB_q};
      end else if (haddr[11:0] == OFS_SAVED_ST) begin
        rdata_q <= savedStatusCopy_q;
      end else if (haddr[11:0] == OFS_SAVED_PC) begin
        rdata_q <= savedCounterCopy_q;
      end else if (haddr[11:0] == OFS_FLAGS2) begin
        rdata_q <= {24'h0, requestFlagsTwo_q}; // RL2
      end else if (isPrioAddr(haddr[11:0])) begin
        rdata_q <= {16'h0, prio_q[3'(haddr[4:2])]};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  // Zero wait states and an OKAY answer every time; both stay in flops so
  // that every bus output of the block is registered like the rest.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      readyOut_q <= 1'b1;
      respOut_q <= 1'b0;
    end else begin
      readyOut_q <= 1'b1;
      respOut_q <= 1'b0;
    end
  end

  // Every output comes straight from its flop.
  assign hreadyout = readyOut_q;
  assign hresp = respOut_q;
  assign hrdata = rdata_q;
  assign pendingRequestOutN = pendN_q;
  assign exceptionTake = take_q;
  assign branchTarget = target_q;

  // ==========================================================================
  // Assertions
  // These watch the entry sequence; a fault in the arbiter shows up as a wrong
  // code or a stray pulse long before it shows up as a hang.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  flagUpperZero_a: assert property (requestFlagsTwo_q[7:5] == 3'h0) // RL2
    else $error("Reserved flag bits not zero.");

  flagMirror_a: assert property (1'b1 |=> requestFlagsTwo_q[4:0] == // RL24
    $past({reqIn[SRC_ADC], reqIn[SRC_TX], reqIn[SRC_BRK], reqIn[SRC_RX], reqIn[SRC_ERR]}))
    else $error("Request flags do not follow their sources.");

  pickIdle_a: assert property (reqIn == '0 |=> !pick_q.valid) // RL8
    else $error("A pick exists with no request.");

  pendLow_a: assert property (pick_q.valid && pick_q.level > status_q.mask // RL11
    |=> !pendingRequestOutN)
    else $error("Pending output not low after acceptance.");

  maskRelease_a: assert property (!(pick_q.valid && pick_q.level > status_q.mask) // RL13
    |=> pendingRequestOutN)
    else $error("Pending output low while source is masked.");

  holdDefer_a: assert property (status_q.hold |=> !exceptionTake) // RL23
    else $error("Entry taken while hold bit set.");

  codeWrite_a: assert property (exceptionTake |-> sourceCodeReg_q == sourceCodeRegB_q // RL15
    && sourceCodeReg_q == codeOf($past(pick_q.idx)))
    else $error("Event registers hold the wrong code.");

  saveCopy_a: assert property (exceptionTake |-> savedCounterCopy_q == $past(cpuPc) // RL16
    && savedStatusCopy_q == packStatus($past(status_q)))
    else $error("Saved copies wrong after entry.");

  entryBits_a: assert property (exceptionTake |-> status_q.hold && status_q.md // RL17
    && status_q.rb && status_q.mask == $past(status_q.mask))
    else $error("Status bits wrong after entry.");

  vectorJump_a: assert property (exceptionTake |-> branchTarget == // RL18
    $past(vectorBase_q) + VECTOR_OFFSET)
    else $error("Branch target is not vector base plus offset.");

  entryCause_a: assert property (exceptionTake |-> $past(instrBoundary) // RL10
    && $past(pick_q.level) > $past(status_q.mask))
    else $error("Entry without boundary or above-mask request.");

  // Each flag bit on its own, so a swapped pair names the bit at fault.
  flagAdc_a: assert property (1'b1 |=> // RL3
    requestFlagsTwo_q[FLAG_ADC_BIT] == $past(reqIn[SRC_ADC]))
    else $error("Converter flag does not follow its source.");

  flagTx_a: assert property (1'b1 |=> // RL4
    requestFlagsTwo_q[FLAG_TX_BIT] == $past(reqIn[SRC_TX]))
    else $error("Transmit flag does not follow its source.");

  flagBreak_a: assert property (1'b1 |=> // RL5
    requestFlagsTwo_q[FLAG_BRK_BIT] == $past(reqIn[SRC_BRK]))
    else $error("Break flag does not follow its source.");

  flagRx_a: assert property (1'b1 |=> // RL6
    requestFlagsTwo_q[FLAG_RX_BIT] == $past(reqIn[SRC_RX]))
    else $error("Receive flag does not follow its source.");

  flagError_a: assert property (1'b1 |=> // RL7
    requestFlagsTwo_q[FLAG_ERR_BIT] == $past(reqIn[SRC_ERR]))
    else $error("Receive error flag does not follow its source.");

  pendStay_a: assert property (!pendingRequestOutN && $stable(pick_q) // RL12
    && $stable(status_q.mask) |=> !pendingRequestOutN)
    else $error("Pending output rose while the request still stood.");

  entryUnheld_a: assert property (exceptionTake |-> !$past(status_q.hold) // RL23
    && $past(pick_q.valid))
    else $error("Entry taken with hold set or nothing picked.");

  takePulse_a: assert property (exceptionTake |=> !exceptionTake) // RL17
    else $error("Entry pulse longer than one cycle.");

  // Registered entry results move only on an entry.
  targetHold_a: assert property ($changed(branchTarget) |-> exceptionTake) // RL18
    else $error("Branch target changed without an entry.");

  codeHold_a: assert property ($changed(sourceCodeReg_q) |-> exceptionTake) // RL15
    else $error("Event code changed without an entry.");

  // Covers for entry, release by masking, nesting and a tie.
  takeSeen_c: cover property (exceptionTake);
  maskedPend_c: cover property (!pendingRequestOutN ##1 pendingRequestOutN && pick_q.valid);
  nestedTake_c: cover property (exceptionTake ##[1:50] exceptionTake);
  tiePick_c: cover property (reqIn[0] && reqIn[1] && prio_q[0][3:0] == prio_q[0][7:4]
    && prio_q[0][3:0] != 4'h0);

endmodule // interrupt_accept_sequencer

// *** tb/cpu_source_model.sv ***
// Behavioural CPU core and request sources facing the interrupt accept sequencer.
module cpu_source_model
  import irq_accept_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [NUM_SRC-1:0] reqWant,
  input wire logic slow,
  input wire logic exceptionTake,
  input wire logic [31:0] branchTarget,
  output logic [NUM_SRC-1:0] reqIn,
  output logic instrBoundary,
  output logic [31:0] cpuPc
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Sources
  logic [1:0] phase_q;
  // Lines are levels that stay up until the handler withdraws the cause.
  always_ff @(posedge clk_sys) begin
    reqIn <= srst ? '0 : reqWant;
  end
  // A slow core meets a boundary every third cycle, like a multi-cycle instruction.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_q <= 2'h0;
      instrBoundary <= 1'b0;
      cpuPc <= 32'h0000_1000;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      instrBoundary <= !slow || phase_q == 2'h2;
      cpuPc <= exceptionTake ? branchTarget : cpuPc + 32'h2;
    end
  end
endmodule // cpu_source_model

// *** tb/test_interrupt_accept_sequencer.sv ***
// Self-checking bench of the interrupt accept sequencer.
module test_interrupt_accept_sequencer
  import irq_accept_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic clk_sys = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, target, pc, rd;
  logic [NUM_SRC-1:0] reqWant = '0, reqIn;
  logic hreadyout, hresp, pend, take, bnd, bdPrev = 1'b0;
  logic [31:0] pcPrev = '0, pcAtTake = '0;
  logic [15:0] rnd = 16'h0042;
  logic [15:0] lvl [NUM_PRIO] = '{default: '0};
  int err_count = 0, total_checks = 0, takes = 0;

  interrupt_accept_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .reqIn(reqIn),
    .instrBoundary(bnd), .cpuPc(pc), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pendingRequestOutN(pend),
    .exceptionTake(take), .branchTarget(target));
  cpu_source_model partner (.clk_sys(clk_sys), .srst(srst), .reqWant(reqWant),
    .slow(slow), .exceptionTake(take), .branchTarget(target), .reqIn(reqIn),
    .instrBoundary(bnd), .cpuPc(pc));

  initial forever #50 clk_sys = ~clk_sys;

  // ==========================================================================
  // Expectations, checks and bus cycles
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] stw(logic h, logic m, logic r, logic [3:0] k);
    return (32'(h) << ST_BL_BIT) | (32'(m) << ST_MD_BIT) | (32'(r) << ST_RB_BIT)
      | (32'(k) << ST_MASK_LSB);
  endfunction
  function automatic logic [31:0] flg(logic [NUM_SRC-1:0] q);
    return {27'h0, q[SRC_ADC], q[SRC_TX], q[SRC_BRK], q[SRC_RX], q[SRC_ERR]};
  endfunction
  function automatic logic [31:0] code(int i);
    return 32'(CODE_BASE) + 32'(CODE_STRIDE) * 32'(i);
  endfunction
  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chkVal(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkBit(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Address phase until hready, then data phase until hready; data taken at that edge.
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    r = hrdata;
    if (hreadyout !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    ahb(1'b1, 32'(a), d, rd);
  endtask
  task automatic rdChk(string nm, logic [11:0] a, logic [31:0] e);
    ahb(1'b0, 32'(a), 32'h0, rd);
    chkVal(nm, e, rd);
  endtask
  task automatic setLevel(int i, logic [3:0] v);
    lvl[i / 4][(i % 4) * 4 +: 4] = v;
    wr(OFS_PRIO0 + 12'(4 * (i / 4)), {16'h0, lvl[i / 4]});
  endtask
  // Waits for the entry pulse, then checks everything that entry must leave behind.
  task automatic expectTake(int i, logic [31:0] st, logic [31:0] vb);
    int n;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (take !== 1'b1 && n < 60);
    if (take !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    chkBit("pendingLow", 1'b0, pend);
    chkVal("branchTarget", vb + VECTOR_OFFSET, target);
    rdChk("code", OFS_CODE, code(i));
    rdChk("codeB", OFS_CODE_B, code(i));
    rdChk("savedStatus", OFS_SAVED_ST, st);
    rdChk("savedPc", OFS_SAVED_PC, pcAtTake);
    rdChk("status", OFS_STATUS, st | stw(1'b1, 1'b1, 1'b1, 4'h0));
    chkBit("pendingHeld", 1'b0, pend);
  endtask

  // Entry must come from a boundary seen in the cycle before the pulse.
  always @(posedge clk_sys) begin
    if (take === 1'b1) begin
      chkBit("boundary", 1'b1, bdPrev);
      takes++;
      pcAtTake <= pcPrev;
    end
    bdPrev <= bnd;
    pcPrev <= pc;
  end

  initial begin
    #3000000;
    err_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] vb;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk("flagsReset", OFS_FLAGS2, 32'h0);
    rdChk("statusReset", OFS_STATUS, stw(1'b1, 1'b1, 1'b0, 4'hf));
    chkBit("hresp", 1'b0, hresp);
    rdChk("unmapped", 12'h040, 32'h0);
    // Random flag patterns, the all-ones pattern first; levels are zero so no entry.
    for (int i = 0; i < 10; i++) begin
      rnd = nx(rnd);
      if (i == 0) rnd[4:0] = 5'h1f;
      reqWant <= {rnd[4:0], 15'h0};
      wr(OFS_FLAGS2, 32'h1f);
      rdChk("flags", OFS_FLAGS2, flg({rnd[4:0], 15'h0}));
    end
    reqWant <= '0;
    repeat (3) @(posedge clk_sys);
    rdChk("flagsGone", OFS_FLAGS2, 32'h0);
    vb = {rnd, 16'h0};
    wr(OFS_VBASE, vb);
    setLevel(2, 4'h9);
    setLevel(SRC_ADC, 4'h9);
    setLevel(7, 4'h6);
    setLevel(SRC_TX, 4'h3);
    setLevel(5, 4'hc);
    reqWant <= 20'h88084;
    slow <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chkBit("pendingMaskF", 1'b1, pend);
    wr(OFS_STATUS, stw(1'b1, 1'b1, 1'b0, 4'h0));
    repeat (4) @(posedge clk_sys);
    chkBit("pendingBlocked", 1'b0, pend);
    chkVal("takesBlocked", 32'h0, 32'(takes));
    wr(OFS_STATUS, stw(1'b0, 1'b1, 1'b0, 4'h0));
    expectTake(2, stw(1'b0, 1'b1, 1'b0, 4'h0), vb);
    slow <= 1'b0;
    reqWant <= 20'h88080;
    rdChk("flagsBack", OFS_FLAGS2, flg(20'h88080));
    repeat (2) @(posedge clk_sys);
    wr(OFS_STATUS, stw(1'b0, 1'b1, 1'b0, 4'h9));
    repeat (6) @(posedge clk_sys);
    chkVal("takesEqual", 32'h1, 32'(takes));
    chkBit("pendingEqual", 1'b1, pend);
    reqWant <= 20'h880a0;
    expectTake(5, stw(1'b0, 1'b1, 1'b0, 4'h9), vb);
    reqWant <= 20'h88080;
    repeat (2) @(posedge clk_sys);
    wr(OFS_STATUS, stw(1'b0, 1'b1, 1'b0, 4'h0));
    expectTake(SRC_ADC, stw(1'b0, 1'b1, 1'b0, 4'h0), vb);
    wr(OFS_STATUS, stw(1'b1, 1'b1, 1'b0, 4'hf));
    repeat (4) @(posedge clk_sys);
    chkBit("pendingMasked", 1'b1, pend);
    tally_and_finish();
  end
endmodule // test_interrupt_accept_sequencer
